// ### rtl/tec_pkg.sv
package tec_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CNTL_OFS = 8'h04;
   localparam logic [7:0] CNTH_OFS = 8'h08;
   localparam logic [7:0] STAT_OFS = 8'h0C;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int PSC_LSB    = 0;
   localparam int EDGE_BIT   = 3;
   localparam int RUN_BIT    = 4;
   localparam int CLKSEL_BIT = 5;
   localparam int MODE_LSB   = 6;
   localparam int FLAG_BIT   = 0;
   localparam int IEN_BIT    = 1;

   // ---------------------------------------------------------------
   // reset values and counts
   // ---------------------------------------------------------------
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [15:0] CNT_RST    = 16'h0000;
   localparam logic [15:0] CNT_ONES   = 16'hFFFF;
   localparam int          SYS_DIV    = 4;
   localparam logic [1:0]  SYS_DIV_M1 = 2'(SYS_DIV - 1);

   typedef enum logic [1:0] {
      MODE_UNUSED = 2'h0,
      MODE_EVENT  = 2'h1,
      MODE_TIMER  = 2'h2,
      MODE_PWM    = 2'h3
   } tec_mode_t;

   typedef struct packed {
      tec_mode_t  mode;
      logic       clk_sel;
      logic       run;
      logic       edge_sel;
      logic [2:0] psc;
   } tec_ctrl_t;

   typedef enum {
      PW_IDLE,
      PW_COUNT,
      PW_DONE
   } tec_pw_t;

endpackage : tec_pkg

// ### rtl/tec_prescaler.sv
`timescale 1ns/1ps
module tec_prescaler
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       tick_in,
   input  wire logic [2:0] sel,
   output logic            tick_out
);

   typedef struct packed {
      logic [6:0] div;
   } tec_psc_st_t;

   tec_psc_st_t st_q;
   tec_psc_st_t st_d;

   // ---------------------------------------------------------------
   // divide tick by 2**sel
   // ---------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      if (tick_in)
      begin
         st_d.div = st_q.div + 7'h01;
      end
   end

   always_comb
   begin
      tick_out = tick_in & ((st_q.div & ((7'h01 << sel) - 7'h01)) == 7'h00);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

endmodule : tec_prescaler

// ### rtl/tec_timer.sv
`timescale 1ns/1ps
// Operation
// - prescale code divides internal clock by 2**code, 000 none to 111 by 128
// - event mode: edge bit set counts falling edges, clear counts rising
// - pulse mode: edge bit set measures high, clear measures low
// - run bit 4 gates counting
// - bit 5 picks system clock / 4 or low-frequency clock
// - bits 7..6 select event, timer or pulse-width mode; 00 unused
// - event mode counts pin edges; timer and pulse modes use internal clock
// - count upward until passing all ones
// - overflow reloads from preload and sets the flag
// - pulse mode counts between transitions then clears run bit
// - after one measurement the count holds until run set again
// - pulse measurement starts on transitions, not levels
// - overflow in pulse mode reloads and flags too
// - run bit never self-clears in event or timer mode
// - overflow is a wake-up source
// - cleared interrupt enable blocks overflow interrupt
// - preload write while stopped also loads counter
// - preload write while running only updates preload
// - counter read blocks counting during its setup and access cycles
// - low byte write buffered; high byte write transfers both
// - high byte read latches both; low byte read returns buffer
module tec_timer
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        timer_pin,
   input  wire logic        lf_clk,
   input  wire logic        irq_ack,
   output logic             irq,
   output logic             wakeup
);

   typedef struct packed {
      logic [1:0]         pin_sync;
      logic               pin_prev;
      logic [1:0]         lf_sync;
      logic               lf_prev;
      logic [1:0]         sys_div;
      tec_pkg::tec_ctrl_t ctrl;
      logic [15:0]        cnt;
      logic [15:0]        preload;
      logic [7:0]         wr_buf;
      logic [7:0]         rd_buf;
      logic               flag;
      logic               ien;
      tec_pkg::tec_pw_t   pw;
      logic [31:0]        rdata;
      logic               wake;
   } tec_st_t;

   tec_st_t    st_q;
   tec_st_t    st_d;
   logic       int_tick;
   logic       base_tick;
   logic       pin_rise;
   logic       pin_fall;
   logic       ev_edge;
   logic       start_edge;
   logic       stop_edge;
   logic       cnt_tick;
   logic       ovf;
   logic       acc;
   logic       wr;
   logic       rd;
   logic       rd_cnt;
   logic       lf_rise;

   // ---------------------------------------------------------------
   // pin and clock edge detection
   // ---------------------------------------------------------------
   assign pin_rise = st_q.pin_sync[1] & ~st_q.pin_prev;
   assign pin_fall = ~st_q.pin_sync[1] & st_q.pin_prev;
   assign lf_rise  = st_q.lf_sync[1] & ~st_q.lf_prev;
   assign ev_edge  = st_q.ctrl.edge_sel ? pin_fall : pin_rise;
   assign start_edge = st_q.ctrl.edge_sel ? pin_rise : pin_fall;
   assign stop_edge  = st_q.ctrl.edge_sel ? pin_fall : pin_rise;

   // internal source: system clock / 4 or low-frequency clock
   assign base_tick = st_q.ctrl.clk_sel ? lf_rise
                                        : (st_q.sys_div == tec_pkg::SYS_DIV_M1);

   tec_prescaler u_psc
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .tick_in  (base_tick),
      .sel      (st_q.ctrl.psc),
      .tick_out (int_tick)
   );

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   assign acc     = psel & penable;
   assign wr      = acc & pwrite;
   assign rd      = psel & ~penable & ~pwrite;
   assign rd_cnt  = psel & ~pwrite & ((paddr == tec_pkg::CNTL_OFS) |
                                     (paddr == tec_pkg::CNTH_OFS));
   assign pready  = 1'b1;
   assign prdata  = st_q.rdata;
   assign irq     = st_q.flag & st_q.ien;
   assign wakeup  = st_q.wake;

   // ---------------------------------------------------------------
   // counting source selection
   // ---------------------------------------------------------------
   always_comb
   begin
      cnt_tick = 1'b0;
      case (st_q.ctrl.mode)
         tec_pkg::MODE_EVENT:  cnt_tick = ev_edge;
         tec_pkg::MODE_TIMER:  cnt_tick = int_tick;
         tec_pkg::MODE_PWM:    cnt_tick = int_tick & (st_q.pw == tec_pkg::PW_COUNT);
         default:              cnt_tick = 1'b0;
      endcase
      cnt_tick = cnt_tick & st_q.ctrl.run & ~rd_cnt;
   end

   assign ovf = cnt_tick & (st_q.cnt == tec_pkg::CNT_ONES);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      st_d          = st_q;
      st_d.pin_sync = {st_q.pin_sync[0], timer_pin};
      st_d.pin_prev = st_q.pin_sync[1];
      st_d.lf_sync  = {st_q.lf_sync[0], lf_clk};
      st_d.lf_prev  = st_q.lf_sync[1];
      st_d.sys_div  = st_q.sys_div + 2'h1;
      st_d.wake     = ovf;

      // counting
      if (ovf)
      begin
         st_d.cnt = st_q.preload;
      end
      else if (cnt_tick)
      begin
         st_d.cnt = st_q.cnt + 16'h0001;
      end

      // pulse-width sequencing
      if (st_q.ctrl.mode == tec_pkg::MODE_PWM && st_q.ctrl.run)
      begin
         case (st_q.pw)
            tec_pkg::PW_IDLE:
            begin
               if (start_edge)
               begin
                  st_d.pw = tec_pkg::PW_COUNT;
               end
            end
            tec_pkg::PW_COUNT:
            begin
               if (stop_edge)
               begin
                  st_d.pw       = tec_pkg::PW_DONE;
                  st_d.ctrl.run = 1'b0;
               end
            end
            default:
            begin
               st_d.pw = st_q.pw;
            end
         endcase
      end
      else if (!st_q.ctrl.run)
      begin
         st_d.pw = st_q.pw;
      end

      // register reads
      if (rd)
      begin
         st_d.rdata = 32'h0000_0000;
         if (paddr == tec_pkg::CTRL_OFS)
         begin
            st_d.rdata[7:0] = st_q.ctrl;
         end
         else if (paddr == tec_pkg::CNTH_OFS)
         begin
            st_d.rdata[7:0] = st_q.cnt[15:8];
            st_d.rd_buf     = st_q.cnt[7:0];
         end
         else if (paddr == tec_pkg::CNTL_OFS)
         begin
            st_d.rdata[7:0] = st_q.rd_buf;
         end
         else if (paddr == tec_pkg::STAT_OFS)
         begin
            st_d.rdata[tec_pkg::FLAG_BIT] = st_q.flag;
            st_d.rdata[tec_pkg::IEN_BIT]  = st_q.ien;
         end
      end

      // register writes
      if (wr)
      begin
         if (paddr == tec_pkg::CTRL_OFS)
         begin
            st_d.ctrl = pwdata[7:0];
            if (pwdata[tec_pkg::RUN_BIT])
            begin
               st_d.pw = tec_pkg::PW_IDLE;
            end
         end
         else if (paddr == tec_pkg::CNTL_OFS)
         begin
            st_d.wr_buf = pwdata[7:0];
         end
         else if (paddr == tec_pkg::CNTH_OFS)
         begin
            st_d.preload = {pwdata[7:0], st_q.wr_buf};
            if (!st_q.ctrl.run)
            begin
               st_d.cnt = {pwdata[7:0], st_q.wr_buf};
            end
         end
         else if (paddr == tec_pkg::STAT_OFS)
         begin
            st_d.ien = pwdata[tec_pkg::IEN_BIT];
            if (pwdata[tec_pkg::FLAG_BIT])
            begin
               st_d.flag = 1'b0;
            end
         end
      end
      if (irq_ack)
      begin
         st_d.flag = 1'b0;
      end
      if (ovf)
      begin
         st_d.flag = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q         <= '0;
         st_q.ctrl    <= tec_pkg::CTRL_RST;
         st_q.cnt     <= tec_pkg::CNT_RST;
         st_q.preload <= tec_pkg::CNT_RST;
         st_q.pw      <= tec_pkg::PW_IDLE;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign pslverr = 1'b0;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_ovf_reload;
      @(posedge pclk) disable iff (!presetn)
      ovf |=> (st_q.cnt == $past(st_q.preload)) && st_q.flag;
   endproperty
   a_ovf_reload: assert property (p_ovf_reload) else $error("no reload on overflow");

   property p_stop_hold;
      @(posedge pclk) disable iff (!presetn)
      (!st_q.ctrl.run && !wr) |=> st_q.cnt == $past(st_q.cnt);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("count moved while stopped");

   property p_read_block;
      @(posedge pclk) disable iff (!presetn)
      (rd_cnt && !wr) |=> st_q.cnt == $past(st_q.cnt);
   endproperty
   a_read_block: assert property (p_read_block) else $error("count moved during read");

   property p_pw_clear;
      @(posedge pclk) disable iff (!presetn)
      (st_q.ctrl.mode == tec_pkg::MODE_PWM && st_q.ctrl.run && st_q.pw == tec_pkg::PW_COUNT
       && stop_edge && !wr) |=> !st_q.ctrl.run;
   endproperty
   a_pw_clear: assert property (p_pw_clear) else $error("run not cleared");

   property p_no_selfclear;
      @(posedge pclk) disable iff (!presetn)
      (st_q.ctrl.run && st_q.ctrl.mode != tec_pkg::MODE_PWM && !wr) |=> st_q.ctrl.run;
   endproperty
   a_no_selfclear: assert property (p_no_selfclear) else $error("run self-cleared");

   property p_irq_mask;
      @(posedge pclk) disable iff (!presetn)
      !st_q.ien |-> !irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked irq");

   property p_wake;
      @(posedge pclk) disable iff (!presetn)
      ovf |=> wakeup ##1 !wakeup || ovf;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake pulse");

   property p_stopped_load;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == tec_pkg::CNTH_OFS && !st_q.ctrl.run)
      |=> st_q.cnt == {$past(pwdata[7:0]), $past(st_q.wr_buf)};
   endproperty
   a_stopped_load: assert property (p_stopped_load) else $error("load missed");

   property p_flag_sticky;
      @(posedge pclk) disable iff (!presetn)
      (st_q.flag && !irq_ack && !wr) |=> st_q.flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

   property p_event_count;
      @(posedge pclk) disable iff (!presetn)
      (st_q.ctrl.mode == tec_pkg::MODE_EVENT && st_q.ctrl.run && ev_edge && !rd_cnt && !wr
       && st_q.cnt != tec_pkg::CNT_ONES) |=> st_q.cnt == $past(st_q.cnt) + 16'h0001;
   endproperty
   a_event_count: assert property (p_event_count) else $error("event edge not counted");

   property p_level_no_start;
      @(posedge pclk) disable iff (!presetn)
      (st_q.pw == tec_pkg::PW_IDLE && !start_edge && !wr) |=> st_q.pw == tec_pkg::PW_IDLE;
   endproperty
   a_level_no_start: assert property (p_level_no_start) else $error("started on a level");

   property p_unused_mode;
      @(posedge pclk) disable iff (!presetn)
      (st_q.ctrl.mode == tec_pkg::MODE_UNUSED && !wr) |=> st_q.cnt == $past(st_q.cnt);
   endproperty
   a_unused_mode: assert property (p_unused_mode) else $error("count moved in unused mode");

endmodule : tec_timer

// ### tb/tec_pin_model.sv
`timescale 1ns/1ps
module tec_pin_model
(
   input  wire logic pclk,
   output logic      pin
);
   initial pin = 1'b0;

   // ---------------------------------------------------------------
   // level change then hold
   // ---------------------------------------------------------------
   task automatic set_lvl(input logic v, input int hold);
      @(posedge pclk);
      pin <= v;
      repeat (hold) @(posedge pclk);
   endtask : set_lvl
endmodule : tec_pin_model

// ### tb/timer_event_counter_tb_top.sv
`timescale 1ns/1ps
module timer_event_counter_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, lf_clk, irq_ack;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, v;
   logic        pready, pslverr, timer_pin, irq, wakeup;
   logic [15:0] c, c0;
   int          fail_count, tests_run, wk_n, w0;

   tec_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_pin(timer_pin), .lf_clk(lf_clk),
      .irq_ack(irq_ack), .irq(irq), .wakeup(wakeup));
   tec_pin_model pin_u (.pclk(pclk), .pin(timer_pin));

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   initial lf_clk = 1'b0;
   always
   begin
      repeat (20) @(posedge pclk);
      lf_clk <= ~lf_clk;
   end

   always @(posedge pclk) if (wakeup === 1'b1) wk_n++;

   // ---------------------------------------------------------------
   // checking and bus tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         fail_count++;
         $display("ERROR %0t: got %h exp %h", $time, s, e);
      end
   endtask : chk

   task automatic near(input logic [31:0] s, input logic [31:0] e);
      chk({31'h0, (s + 32'h1 >= e) && (s <= e + 32'h1)}, 32'h1);
   endtask : near

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      v = prdata;
      chk(pslverr, 1'b0);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic ld(input logic [15:0] x);
      apb(1'b1, tec_pkg::CNTL_OFS, {24'h0, x[7:0]});
      apb(1'b1, tec_pkg::CNTH_OFS, {24'h0, x[15:8]});
   endtask : ld

   task automatic rd_cnt();
      apb(1'b0, tec_pkg::CNTH_OFS, 32'h0);
      c[15:8] = v[7:0];
      apb(1'b0, tec_pkg::CNTL_OFS, 32'h0);
      c[7:0] = v[7:0];
   endtask : rd_cnt

   task automatic end_sim();
      $display("checks %0d errors %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   initial
   begin
      #300000;
      fail_count++;
      end_sim();
   end

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial
   begin
      {psel, penable, pwrite, irq_ack, presetn} = 5'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, tec_pkg::CTRL_OFS, 32'h0);
      chk(v, {24'h0, tec_pkg::CTRL_RST});
      apb(1'b0, tec_pkg::STAT_OFS, 32'h0);
      chk(v, 32'h0);
      apb(1'b1, 8'h10, 32'hFF);
      apb(1'b0, 8'h10, 32'h0);
      chk(v, 32'h0);
      ld(16'h1234);
      rd_cnt();
      chk(c, 16'h1234);
      for (int e = 0; e < 2; e++)
      begin
         apb(1'b1, tec_pkg::CTRL_OFS, 32'h40);
         ld(16'h0000);
         apb(1'b1, tec_pkg::CTRL_OFS, 32'h50 | (e << 3));
         pin_u.set_lvl(1'b1, 8);
         rd_cnt();
         chk(c, 16'(1 - e));
         pin_u.set_lvl(1'b0, 8);
         rd_cnt();
         chk(c, 16'h0001);
      end
      apb(1'b0, tec_pkg::CTRL_OFS, 32'h0);
      chk(v, 32'h58);
      apb(1'b1, tec_pkg::CTRL_OFS, 32'h40);
      ld(16'hFFFE);
      apb(1'b1, tec_pkg::CTRL_OFS, 32'h50);
      ld(16'h0010);
      rd_cnt();
      chk(c, 16'hFFFE);
      w0 = wk_n;
      repeat (2)
      begin
         pin_u.set_lvl(1'b1, 8);
         pin_u.set_lvl(1'b0, 8);
      end
      rd_cnt();
      chk(c, 16'h0010);
      chk(irq, 1'b0);
      chk(wk_n - w0, 1);
      apb(1'b1, tec_pkg::STAT_OFS, 32'h2);
      apb(1'b0, tec_pkg::STAT_OFS, 32'h0);
      chk(v, 32'h3);
      chk(irq, 1'b1);
      irq_ack <= 1'b1;
      @(posedge pclk);
      irq_ack <= 1'b0;
      apb(1'b0, tec_pkg::STAT_OFS, 32'h0);
      chk(v, 32'h2);
      for (int p = 0; p < 8; p++)
      begin
         apb(1'b1, tec_pkg::CTRL_OFS, 32'h80);
         ld(16'h0000);
         apb(1'b1, tec_pkg::CTRL_OFS, 32'h90 | p);
         repeat (32 << p) @(posedge pclk);
         apb(1'b1, tec_pkg::CTRL_OFS, 32'h80 | p);
         rd_cnt();
         near(c, 32'h8);
      end
      ld(16'h0000);
      apb(1'b1, tec_pkg::CTRL_OFS, 32'h10);
      repeat (64) @(posedge pclk);
      apb(1'b1, tec_pkg::CTRL_OFS, 32'h80);
      repeat (64) @(posedge pclk);
      rd_cnt();
      chk(c, 16'h0000);
      apb(1'b1, tec_pkg::CTRL_OFS, 32'hB0);
      repeat (240) @(posedge pclk);
      apb(1'b1, tec_pkg::CTRL_OFS, 32'hA0);
      rd_cnt();
      near(c, 32'h6);
      apb(1'b1, tec_pkg::CTRL_OFS, 32'hC0);
      ld(16'h0000);
      pin_u.set_lvl(1'b1, 4);
      apb(1'b1, tec_pkg::CTRL_OFS, 32'hD8);
      repeat (40) @(posedge pclk);
      rd_cnt();
      chk(c, 16'h0000);
      pin_u.set_lvl(1'b0, 8);
      pin_u.set_lvl(1'b1, 64);
      pin_u.set_lvl(1'b0, 8);
      rd_cnt();
      c0 = c;
      near(c, 32'h10);
      apb(1'b0, tec_pkg::CTRL_OFS, 32'h0);
      chk(v, 32'hC8);
      pin_u.set_lvl(1'b1, 64);
      pin_u.set_lvl(1'b0, 8);
      rd_cnt();
      chk(c, c0);
      apb(1'b1, tec_pkg::CTRL_OFS, 32'hC0);
      ld(16'hFFF8);
      pin_u.set_lvl(1'b1, 8);
      apb(1'b1, tec_pkg::CTRL_OFS, 32'hD0);
      pin_u.set_lvl(1'b0, 64);
      pin_u.set_lvl(1'b1, 8);
      apb(1'b0, tec_pkg::STAT_OFS, 32'h0);
      chk(v, 32'h3);
      apb(1'b0, tec_pkg::CTRL_OFS, 32'h0);
      chk(v, 32'hC0);
      end_sim();
   end
endmodule : timer_event_counter_tb_top
